//--- shp_buf.sv
/*
  two-entry valid/ready buffer used as the receive fifo's stage.
  assumes same-clock producer and consumer.
*/
`timescale 1ns/1ps
`default_nettype none
module shp_buf
  import shp_pkg::*;
#(
  parameter int W = WORD_W
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst,      // async reset
  input  wire logic         clr,      // synchronous flush
  input  wire logic         in_valid, // word offered
  output logic              in_ready, // room for a word
  input  wire logic [W-1:0] in_data,  // word in
  output logic              out_valid,// word available
  input  wire logic         out_ready,// consumer takes word
  output logic [W-1:0]      out_data  // oldest word
);
  logic [W-1:0] mem_ff [2];
  logic         rd_ff;
  logic         wr_ff;
  logic [1:0]   cnt_ff;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = cnt_ff != 2'h2;
  assign out_valid = cnt_ff != 2'h0;
  assign out_data  = mem_ff[rd_ff];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ff  <= 1'b0;
      wr_ff  <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end
    else if (clr)
    begin
      rd_ff  <= 1'b0;
      wr_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      if (push)
        mem_ff[wr_ff] <= in_data;
      if (push)
        wr_ff <= ~wr_ff;
      if (pop)
        rd_ff <= ~rd_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : shp_buf
`default_nettype wire

//--- shp_far_model.sv
/*
  far-side spi model: a clock_polarity_select 0 clock_phase_select 1 slave for the port as master, and a
  master task that clocks the port as slave. assumes one calling process.
*/
`timescale 1ns/1ps
`default_nettype none
module shp_far_model
  import shp_pkg::*;
(
  input  wire logic sck_out,  // port clock out
  input  wire logic sdo_out,  // port data out
  input  wire logic sdo_oe_n, // low = port drives
  output logic      sck_in,   // clock to port
  output logic      sdi_in,   // data to port
  output logic      ss_n_in,  // select to port
  output logic      req_n     // request to port
);
  logic [WORD_W-1:0] sh = 8'h00;  // slave shift register
  logic              mst = 1'b0;  // 1 = model clocks the port
  logic              mosi = 1'b1;
  logic              miso = 1'b1;
  assign sdi_in = mst ? mosi : miso;
  initial
  begin
    sck_in = 1'b0;
    ss_n_in = 1'b1;
    req_n = 1'b1;
  end
  always @(posedge sck_out)
  begin
    miso <= sh[WORD_W-1];
    req_n <= 1'b1;
  end
  always @(negedge sck_out)
    sh <= {sh[WORD_W-2:0], sdo_out};
  task load(input logic [WORD_W-1:0] d);
    mst = 1'b0;
    sh = d;
    req_n = 1'b0;
  endtask : load
  // n below a full word drops select early to force an abort
  task xfer(input logic [WORD_W-1:0] d, input int n, output logic [WORD_W-1:0] r);
    mst = 1'b1;
    ss_n_in = 1'b0;
    #64;
    for (int i = 0; i < n; i++)
    begin
      mosi = d[WORD_W-1-i];
      sck_in = 1'b1;
      #32;
      // phase-one master samples on the trailing edge
      r = {r[WORD_W-2:0], sdo_oe_n ? ~r[0] : sdo_out};
      sck_in = 1'b0;
      #32;
    end
    ss_n_in = 1'b1;
    mosi = ~mosi;
    #64;
  endtask : xfer
endmodule : shp_far_model
`default_nettype wire

//--- shp_pkg.sv
/*
  shared constants, field layouts and status carrier for the serial host port
  (spi slave/master and i2c master). assumes a single sys_clk domain; all
  serial pins are asynchronous and synchronised inside the port.
*/
// Summary of operation
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - i2c data stable while scl high
// - ninth clock pulse carries acknowledge bit
// - receiver acknowledges by holding sda low
// - master receiver withholds ack on last byte
// - i2c master waits while slave stretches scl
// - first byte: seven-bit address plus direction
// - i2c master ends every transfer with stop
// - standard and fast i2c clock rates supported
// - enable, protocol and master select choose mode
// - spi slave uses only phase and polarity
// - spi slave loads shift register between words
// - no transmit write means retransmit shift register
// - slave request per request-enable field setting
// - slave request drops at next word's clock
// - select dropped mid-word aborts, discards word
// - select asserted in spi master sets error
// - spi master transfer starts on transmit write
// - master honours request only when enabled
// - master withholds clock while request deasserted
// - phase zero master: empty after word ends
// - full fifo at word end sets overrun; the i2c master instead overwrites the held word without setting it
// - busy follows select or holding/shift contents
package shp_pkg;
  localparam int WORD_W      = 8;
  localparam int FIFO_DEPTH  = 4;
  localparam int SYS_CLK_HZ  = 125000000;
  localparam int I2C_STD_HZ  = 100000;
  localparam int I2C_FAST_HZ = 400000;
  localparam int SPI_HALF_DEF = 4;
  localparam int I2C_STD_HALF  = SYS_CLK_HZ / (2 * I2C_STD_HZ);
  localparam int I2C_FAST_HALF = SYS_CLK_HZ / (2 * I2C_FAST_HZ);
  localparam logic [1:0] REQ_OFF  = 2'h0;
  localparam logic [1:0] REQ_RX   = 2'h1;
  localparam logic [1:0] REQ_TX   = 2'h2;
  localparam logic [1:0] REQ_BOTH = 2'h3;
  localparam logic [3:0] I2C_BITS = 4'h9;

  typedef struct packed {
    logic transmit_empty_flag;
    logic receive_not_empty_flag;
    logic receive_overrun_flag;
    logic bus_error_flag;
    logic port_busy_flag;
    logic i2c_nack_flag;
  } shp_status_t;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_START = 3'b001,
    I2C_LOW   = 3'b010,
    I2C_HIGH  = 3'b011,
    I2C_STOP1 = 3'b100,
    I2C_STOP2 = 3'b101
  } shp_i2c_state_t;
endpackage : shp_pkg

//--- shp_port.sv
/*
  serial host port top: spi slave, spi master and i2c master engines sharing
  a transmit holding register, a shift register and a receive buffer.
  assumes all serial pins are asynchronous to sys_clk; open-drain lines are split
  into in/out/oe with oe_n low while driving.
*/
`timescale 1ns/1ps
`default_nettype none
module shp_port
  import shp_pkg::*;
#(
  parameter int W        = WORD_W,
  parameter int SPI_HALF = SPI_HALF_DEF
) (
  input  wire logic         sys_clk,               // 125 MHz clock
  input  wire logic         rst,                   // async reset, high
  input  wire logic         port_enable,           // low = individual reset
  input  wire logic         protocol_select,       // 1 = i2c
  input  wire logic         master_select,         // 1 = master
  input  wire logic         clock_phase_select,    // spi phase
  input  wire logic         clock_polarity_select, // spi polarity
  input  wire logic         i2c_fast,              // 1 = 400 kHz
  input  wire logic [1:0]   request_enable_field,  // handshake select
  input  wire logic         bus_error_irq_enable,  // error irq mask
  input  wire logic         tx_write,              // load holding register
  input  wire logic [W-1:0] tx_data,               // holding data
  input  wire logic         rx_ready,              // consumer pops word
  output logic              rx_valid,              // word available
  output logic [W-1:0]      rx_data,               // received word
  output shp_status_t       status,                // status flags
  output logic              bus_error_irq,         // error interrupt
  input  wire logic         sck_in,                // spi clock / scl in
  output logic              sck_out,               // spi clock / scl out
  output logic              sck_oe_n,              // low = drive sck/scl
  input  wire logic         sdi_in,                // mosi/miso/sda in
  output logic              sdo_out,               // data out
  output logic              sdo_oe_n,              // low = drive data
  input  wire logic         ss_n_in,               // slave select, low
  input  wire logic         host_req_n_in,         // request from slave
  output logic              host_req_n_out         // request to master
);
  // two-stage synchronisers; the first stage feeds only the second
  logic [1:0] sck_s_ff, sdi_s_ff, ss_s_ff, req_s_ff;
  logic       sck_d_ff, sdi_d_ff, ss_d_ff;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_s_ff <= 2'h3;
      sdi_s_ff <= 2'h3;
      ss_s_ff  <= 2'h3;
      req_s_ff <= 2'h3;
      sck_d_ff <= 1'b1;
      sdi_d_ff <= 1'b1;
      ss_d_ff  <= 1'b1;
    end
    else
    begin
      sck_s_ff <= {sck_s_ff[0], sck_in};
      sdi_s_ff <= {sdi_s_ff[0], sdi_in};
      ss_s_ff  <= {ss_s_ff[0], ss_n_in};
      req_s_ff <= {req_s_ff[0], host_req_n_in};
      sck_d_ff <= sck_s_ff[1];
      sdi_d_ff <= sdi_s_ff[1];
      ss_d_ff  <= ss_s_ff[1];
    end
  end
  wire sck_q = sck_s_ff[1];
  wire sdi_q = sdi_s_ff[1];
  wire ss_q  = ss_s_ff[1];
  wire req_q = req_s_ff[1];

  // mode decode
  wire spi_slv = port_enable && !protocol_select && !master_select;
  wire spi_mst = port_enable && !protocol_select && master_select;
  wire i2c_mst = port_enable && protocol_select && master_select;
  wire clr     = !port_enable;

  // spi slave: only phase and polarity matter; leading/trailing edges
  wire sck_rise  = sck_q && !sck_d_ff;
  wire sck_fall  = !sck_q && sck_d_ff;
  wire lead_edge = clock_polarity_select ? sck_fall : sck_rise;
  wire trail_edge = clock_polarity_select ? sck_rise : sck_fall;
  wire ss_act    = spi_slv && !ss_q;
  wire ss_rise   = spi_slv && ss_q && !ss_d_ff;
  wire slv_samp  = ss_act && (clock_phase_select ? trail_edge : lead_edge);
  wire slv_shift = ss_act && (clock_phase_select ? lead_edge : trail_edge);

  localparam int CW = $clog2(2 * W + 2);
  logic [W-1:0]  txh_ff;
  logic          txh_full_ff;
  logic [W-1:0]  sh_ff;
  logic          sh_full_ff;
  logic [CW-1:0] bit_ff;
  logic          rxw_valid_ff;
  logic [W-1:0]  rxw_ff;
  logic          ovr_ff, berr_ff, nack_ff, req_out_ff, irq_ff;
  logic          txe_ff;
  logic          in_ready;
  logic          slv_first_ff;

  // master side counters
  logic [15:0]   div_ff;
  logic          msck_ff, mdo_ff, mact_ff;
  logic          sda_oe_ff, scl_oe_ff;
  shp_i2c_state_t ist_ff;
  logic          irw_ff, iaddr_ff, ilast_ff;

  wire [15:0] half_cnt = i2c_mst ? (i2c_fast ? 16'(I2C_FAST_HALF) : 16'(I2C_STD_HALF))
                                 : 16'(SPI_HALF);
  wire tick = div_ff == 16'h0;

  // spi master handshake gate, spi slave load and request
  wire req_ok    = (request_enable_field == REQ_OFF) || !req_q;
  wire mst_start = spi_mst && !mact_ff && txh_full_ff && req_ok && ss_q;
  wire slv_edge  = slv_samp || slv_shift;
  // loads while idle too, so a master waiting on the request is not deadlocked
  wire slv_load  = spi_slv && txh_full_ff && slv_first_ff && !slv_edge;
  wire req_rx_ok = !request_enable_field[0] || in_ready;
  wire req_tx_ok = !request_enable_field[1] || sh_full_ff;
  wire slv_req   = spi_slv && slv_first_ff && request_enable_field != REQ_OFF
                   && req_rx_ok && req_tx_ok;

  // word completion into the receive buffer
  wire slv_done = slv_samp && bit_ff == CW'(W - 1);
  wire mst_done = spi_mst && mact_ff && tick && msck_ff == !clock_polarity_select
                  && bit_ff == CW'(2 * W - 1);
  wire [W-1:0] slv_word = {sh_ff[W-2:0], sdi_q};

  shp_buf #(.W(W)) u_rxbuf (
    .clk      (sys_clk),
    .rst      (rst),
    .clr      (clr),
    .in_valid (rxw_valid_ff),
    .in_ready (in_ready),
    .in_data  (rxw_ff),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data (rx_data)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      txh_ff <= '0; txh_full_ff <= 1'b0; txe_ff <= 1'b1;
      sh_ff <= '0; sh_full_ff <= 1'b0; bit_ff <= '0;
      rxw_valid_ff <= 1'b0; rxw_ff <= '0; ovr_ff <= 1'b0;
      berr_ff <= 1'b0; nack_ff <= 1'b0; req_out_ff <= 1'b1;
      irq_ff <= 1'b0; slv_first_ff <= 1'b1;
      div_ff <= '0; msck_ff <= 1'b0; mdo_ff <= 1'b1; mact_ff <= 1'b0;
      sda_oe_ff <= 1'b1; scl_oe_ff <= 1'b1; ist_ff <= I2C_IDLE;
      irw_ff <= 1'b0; iaddr_ff <= 1'b0; ilast_ff <= 1'b0;
    end
    else if (clr)
    begin
      txh_full_ff <= 1'b0; txe_ff <= 1'b1; sh_full_ff <= 1'b0;
      bit_ff <= '0; rxw_valid_ff <= 1'b0; ovr_ff <= 1'b0;
      berr_ff <= 1'b0; nack_ff <= 1'b0; req_out_ff <= 1'b1;
      irq_ff <= 1'b0; slv_first_ff <= 1'b1; mact_ff <= 1'b0;
      msck_ff <= clock_polarity_select; sda_oe_ff <= 1'b1;
      scl_oe_ff <= 1'b1; ist_ff <= I2C_IDLE; div_ff <= '0;
    end
    else
    begin
      div_ff <= tick ? half_cnt : div_ff - 16'h1;
      if (rxw_valid_ff && in_ready)
        rxw_valid_ff <= 1'b0;
      if (tx_write)
      begin
        txh_ff <= tx_data;
        txh_full_ff <= 1'b1;
        txe_ff <= 1'b0;
      end
      // spi slave
      // the first clock edge of a word drops the request
      req_out_ff <= !(slv_req && !slv_edge);
      if (slv_load)
      begin
        sh_ff <= txh_ff;
        sh_full_ff <= 1'b1;
        txh_full_ff <= tx_write;
        txe_ff <= !tx_write;
      end
      if (slv_edge)
      begin
        sh_full_ff <= 1'b0;
        slv_first_ff <= 1'b0;
      end
      if (slv_samp)
      begin
        sh_ff <= slv_word;     // shift register takes in the sampled sdi bit
        bit_ff <= slv_done ? '0 : bit_ff + CW'(1);
        slv_first_ff <= slv_done;
        if (slv_done && (rxw_valid_ff && !in_ready))
          ovr_ff <= 1'b1;
        else if (slv_done)
        begin
          rxw_ff <= slv_word;
          rxw_valid_ff <= 1'b1;
        end
      end
      if (ss_rise)
      begin
        bit_ff <= '0;
        slv_first_ff <= 1'b1;
      end
      // spi master
      if (spi_mst && !ss_q)
        berr_ff <= 1'b1;
      irq_ff <= (berr_ff || (spi_mst && !ss_q)) && bus_error_irq_enable;
      if (mst_start)
      begin
        sh_ff <= txh_ff;
        txh_full_ff <= tx_write;
        if (clock_phase_select)
          txe_ff <= !tx_write;
        mact_ff <= 1'b1;
        bit_ff <= '0;
        msck_ff <= clock_polarity_select;
        mdo_ff <= txh_ff[W-1];
      end
      else if (spi_mst && mact_ff && tick)
      begin
        msck_ff <= !msck_ff;
        bit_ff <= bit_ff + CW'(1);
        if (bit_ff[0] == clock_phase_select)
          sh_ff <= {sh_ff[W-2:0], sdi_q};
        else
          mdo_ff <= sh_ff[W-1];
        if (mst_done)
        begin
          mact_ff <= 1'b0;
          if (!clock_phase_select && !tx_write && !txh_full_ff)
            txe_ff <= 1'b1;
          if (rxw_valid_ff && !in_ready)
            ovr_ff <= 1'b1;
          else
          begin
            // phase zero took its last bit a half period earlier
            rxw_ff <= clock_phase_select ? {sh_ff[W-2:0], sdi_q} : sh_ff;
            rxw_valid_ff <= 1'b1;
          end
        end
      end
      // i2c master: one byte per holding write, stop after every transfer
      if (i2c_mst && tick)
      begin
        case (ist_ff)
          I2C_IDLE:
            if (txh_full_ff)
            begin
              sda_oe_ff <= 1'b0;
              sh_ff <= txh_ff;
              irw_ff <= txh_ff[0];
              iaddr_ff <= 1'b1;
              txh_full_ff <= tx_write;
              txe_ff <= !tx_write;
              bit_ff <= '0;
              ist_ff <= I2C_START;
            end
          I2C_START:
          begin
            scl_oe_ff <= 1'b0;
            ist_ff <= I2C_LOW;
          end
          I2C_LOW:
          begin
            if (bit_ff == CW'(I2C_BITS - 1))
              sda_oe_ff <= (irw_ff && !iaddr_ff) ? ilast_ff : 1'b1;
            else
              sda_oe_ff <= (irw_ff && !iaddr_ff) ? 1'b1 : sh_ff[W-1];
            scl_oe_ff <= 1'b1;
            ist_ff <= I2C_HIGH;
          end
          I2C_HIGH:
            if (sck_q)
            begin
              scl_oe_ff <= 1'b0;
              if (bit_ff == CW'(I2C_BITS - 1))
              begin
                bit_ff <= '0;
                ilast_ff <= !txh_full_ff;
                if (!irw_ff || iaddr_ff)
                  nack_ff <= sdi_q;
                iaddr_ff <= 1'b0;
                if (irw_ff && !iaddr_ff)
                begin
                  rxw_ff <= sh_ff;
                  rxw_valid_ff <= 1'b1;
                end
                if (sdi_q && (!irw_ff || iaddr_ff))
                  ist_ff <= I2C_STOP1;
                else if (txh_full_ff)
                begin
                  sh_ff <= txh_ff;
                  txh_full_ff <= tx_write;
                  txe_ff <= !tx_write;
                  ist_ff <= I2C_LOW;
                end
                else
                  ist_ff <= (irw_ff && !ilast_ff) ? I2C_LOW : I2C_STOP1;
              end
              else
              begin
                sh_ff <= {sh_ff[W-2:0], sdi_q};
                bit_ff <= bit_ff + CW'(1);
                ist_ff <= I2C_LOW;
              end
            end
          I2C_STOP1:
          begin
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b1;
            ist_ff <= I2C_STOP2;
          end
          I2C_STOP2:
          begin
            sda_oe_ff <= 1'b1;
            ist_ff <= I2C_IDLE;
          end
          default:
            ist_ff <= I2C_IDLE;
        endcase
      end
    end
  end

  // registered pin and status drive
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_out <= 1'b0; sck_oe_n <= 1'b1; sdo_out <= 1'b1; sdo_oe_n <= 1'b1;
      host_req_n_out <= 1'b1; status <= '0; bus_error_irq <= 1'b0;
    end
    else
    begin
      sck_out  <= i2c_mst ? 1'b0 : (mact_ff ? msck_ff : clock_polarity_select);
      sck_oe_n <= i2c_mst ? scl_oe_ff : !spi_mst;
      sdo_out  <= i2c_mst ? 1'b0 : (spi_mst ? mdo_ff : sh_ff[W-1]);
      sdo_oe_n <= i2c_mst ? sda_oe_ff : !(spi_mst || ss_act);
      host_req_n_out <= spi_slv ? req_out_ff : 1'b1;
      bus_error_irq  <= irq_ff;
      status.transmit_empty_flag    <= txe_ff;
      status.receive_not_empty_flag <= rx_valid;
      status.receive_overrun_flag   <= ovr_ff;
      status.bus_error_flag         <= berr_ff;
      status.port_busy_flag <= spi_slv ? !ss_q :
                               (spi_mst ? (txh_full_ff || mact_ff) : ist_ff != I2C_IDLE);
      status.i2c_nack_flag          <= nack_ff;
    end
  end

  a_berr_sets: assert property (@(posedge sys_clk) disable iff (rst)
    (spi_mst && !ss_q && port_enable) |=> berr_ff)
    else $error("bus error not set on select in master");
  a_ovr_keeps: assert property (@(posedge sys_clk) disable iff (rst)
    ((slv_done || mst_done) && rxw_valid_ff && !in_ready && port_enable)
      |=> ovr_ff && !(rxw_ff != $past(rxw_ff)))
    else $error("overrun word not held");
  a_abort_clr: assert property (@(posedge sys_clk) disable iff (rst)
    (ss_rise && port_enable) |=> bit_ff == '0)
    else $error("partial word not discarded");
  a_mst_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (spi_mst && request_enable_field != REQ_OFF && req_q && !mact_ff) |=> !mact_ff)
    else $error("master clocked without request");
  a_txe_cpha0: assert property (@(posedge sys_clk) disable iff (rst)
    (mst_start && !clock_phase_select && !tx_write && port_enable) |=> !txe_ff)
    else $error("empty flag set too early");
  a_stop_end: assert property (@(posedge sys_clk) disable iff (rst)
    (i2c_mst && ist_ff == I2C_STOP2 && tick) |=> sda_oe_ff && ist_ff == I2C_IDLE)
    else $error("stop not completed");
  a_stretch_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (i2c_mst && ist_ff == I2C_HIGH && !sck_q) |=> ist_ff == I2C_HIGH)
    else $error("master ignored clock stretch");
  a_busy_slave: assert property (@(posedge sys_clk) disable iff (rst)
    (spi_slv && !ss_q) |=> status.port_busy_flag)
    else $error("busy not set under select");
endmodule : shp_port
`default_nettype wire

//--- test_shp_port.sv
/*
  self-checking bench for the serial host port in spi master and slave modes.
  assumes the far-side model answers with clock polarity 0.
*/
`timescale 1ns/1ps
`default_nettype none
module test_shp_port;
  import shp_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              port_enable = 1'b1;
  logic              master_select = 1'b1;
  logic              clock_phase_select = 1'b1;
  logic [1:0]        request_enable_field = REQ_OFF;
  logic              tx_write = 1'b0;
  logic [WORD_W-1:0] tx_data = 8'h00;
  logic              rx_ready = 1'b0;
  logic              rx_en = 1'b0;
  logic              irq_en = 1'b0;
  logic              rx_valid;
  logic [WORD_W-1:0] rx_data;
  shp_status_t       status;
  logic              bus_error_irq, sck_in, sck_out, sck_oe_n, sdi_in, sdo_out, sdo_oe_n;
  logic              ss_n_in, req_n, host_req_n_out;
  logic [WORD_W-1:0] r;
  logic [WORD_W-1:0] exp_q[$];
  int                fails = 0;
  int                checks = 0;

  shp_port u_dut (
    .sys_clk(sys_clk), .rst(rst), .port_enable(port_enable), .protocol_select(1'b0),
    .master_select(master_select), .clock_phase_select(clock_phase_select),
    .clock_polarity_select(1'b0), .i2c_fast(1'b0),
    .request_enable_field(request_enable_field), .bus_error_irq_enable(irq_en),
    .tx_write(tx_write), .tx_data(tx_data), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .status(status), .bus_error_irq(bus_error_irq), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi_in(sdi_in), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .ss_n_in(ss_n_in), .host_req_n_in(req_n),
    .host_req_n_out(host_req_n_out)
  );
  shp_far_model u_far (
    .sck_out(sck_out), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .sck_in(sck_in),
    .sdi_in(sdi_in), .ss_n_in(ss_n_in), .req_n(req_n)
  );

  always #4 sys_clk = ~sys_clk;
  // the consumer stalls at random so the receive buffer backs up
  always @(posedge sys_clk)
  begin
    #1;
    rx_ready = rx_en && ($urandom_range(1) != 0);
  end

  task automatic complete_run;
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [WORD_W-1:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // looked at half a cycle before the popping edge, where both are settled
  always @(negedge sys_clk)
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("rx_extra", 8'h01, 8'h00);
      else
        chk("rx_data", rx_data, exp_q.pop_front());
    end

  function automatic logic cond(input int s);
    case (s)
      0: return status.transmit_empty_flag === 1'b1 && status.port_busy_flag === 1'b0;
      1: return exp_q.size() == 0;
      default: return status.bus_error_flag === 1'b1;
    endcase
  endfunction : cond

  task automatic wait_on(input int s);
    int n;
    n = 0;
    while (!cond(s) && n < 3000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 3000)
    begin
      fails++;
      complete_run;
    end
  endtask : wait_on

  task automatic preset(input logic ph, input logic ms);
    port_enable = 1'b0;
    @(posedge sys_clk);
    #1;
    clock_phase_select = ph;
    master_select = ms;
    repeat (2) @(posedge sys_clk);
    #1;
    port_enable = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : preset

  task automatic txw(input logic [WORD_W-1:0] d);
    tx_write = 1'b1;
    tx_data = d;
    @(posedge sys_clk);
    #1;
    tx_write = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : txw

  task automatic mwrite(input logic [WORD_W-1:0] d, input logic ld);
    logic [WORD_W-1:0] s;
    s = ld ? WORD_W'($urandom) : u_far.sh;
    if (ld) u_far.load(s);
    exp_q.push_back(s);
    txw(d);
    chk("busy", {7'h00, status.port_busy_flag}, 8'h01);
    wait_on(0);
    chk("far_rx", u_far.sh, d);
  endtask : mwrite

  initial
  begin
    void'($urandom(96));
    repeat (10) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("status_rst", {2'b00, status}, 8'h20);
    rx_en = 1'b1;
    repeat (2) mwrite(WORD_W'($urandom), 1'b1);
    mwrite(8'hA5, 1'b0);
    request_enable_field = REQ_TX;
    exp_q.push_back(8'hC3);
    txw(8'h3C);
    repeat (200) @(posedge sys_clk);
    #1;
    chk("gated", {7'h00, status.port_busy_flag}, 8'h01);
    u_far.load(8'hC3);
    wait_on(0);
    chk("far_rx", u_far.sh, 8'h3C);
    request_enable_field = REQ_OFF;
    u_far.ss_n_in = 1'b0;
    wait_on(2);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq_off", {7'h00, bus_error_irq}, 8'h00);
    irq_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("irq", {7'h00, bus_error_irq}, 8'h01);
    u_far.ss_n_in = 1'b1;
    wait_on(1);
    rx_en = 1'b0;
    preset(1'b0, 1'b1);
    chk("err_clr", {7'h00, status.bus_error_flag}, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      txw(WORD_W'(i));
      if (i == 0) chk("tx_empty", {7'h00, status.transmit_empty_flag}, 8'h00);
      wait_on(0);
    end
    chk("overrun", {7'h00, status.receive_overrun_flag}, 8'h01);
    preset(1'b1, 1'b0);
    chk("rx_empty", {7'h00, status.receive_not_empty_flag}, 8'h00);
    rx_en = 1'b1;
    txw(8'h5A);
    for (int k = 0; k < 4; k++)
    begin
      request_enable_field = 2'(k);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("req", {7'h00, host_req_n_out}, {7'h00, k == 0});
    end
    exp_q.push_back(8'h96);
    u_far.xfer(8'h96, 8, r);
    chk("miso", r, 8'h5A);
    chk("req_drop", {7'h00, host_req_n_out}, 8'h01);
    exp_q.push_back(8'h69);
    u_far.xfer(8'h69, 8, r);
    chk("miso", r, 8'h96);
    u_far.xfer(8'hF0, 4, r);
    exp_q.push_back(8'h0F);
    u_far.xfer(8'h0F, 8, r);
    wait_on(1);
    complete_run;
  end
endmodule : test_shp_port
`default_nettype wire
